// >>> hdl/fbce_dev.sv
// flash buffer command engine, device end
// Notes on behaviour
// - D4h/D6h read buffer one/two, fast
// - D1h/D3h read buffer one/two, slow
// - 264 option: 15 don't-care, 9-bit index
// - 256 option: 16 don't-care, 8-bit index
// - fast reads take one dummy byte first
// - reads wrap to first buffer byte
// - chip select rise ends read, releases output
// - chip select low for whole read
// - 84h/87h write buffer one/two
// - writes store successively, wrap, stop on deselect
// - 83h/86h program buffer with erase
// - 264 option: 4 dc, 11 page, 9 trailing
// - 256 option: 5 dc, 11 page, 8 trailing
// - deselect starts erase then program
// - busy flag while self-timed work runs
// - verify bytes, flag erase-program error
// - 88h/89h program buffer without erase
// - 256 no-erase: 5 dc, 11 page, 8 dc
// - host erases page before no-erase program
// - 82h/85h load buffer, erase, program
// - loading starts at index, wraps
// - partial byte at deselect aborts program
`default_nettype none
module fbce_dev #(
  parameter int PAGES_N = fbce_pkg::PAGES_DEF
) (
  // core clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // page size option strap, high selects 264 bytes
  input  wire logic        page264_i,
  // status
  output logic             busy_o,
  output logic             erase_program_error_flag_o,
  // main array observation port
  input  wire logic [10:0] arr_page_i,
  input  wire logic [8:0]  arr_byte_i,
  output logic [7:0]       arr_data_o,
  // serial link
  fbce_link_if.dev         link
);
  localparam int AW = $clog2(PAGES_N * fbce_pkg::PAGE_MAX);
  localparam int BW = $clog2(2 * fbce_pkg::PAGE_MAX);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG  = 3'b100
  } fbce_st_t;

  // two page buffers, written and read at the link, read by the engine
  logic [7:0]  buf_mem [0:2*fbce_pkg::PAGE_MAX-1];
  logic [7:0]  arr_mem [0:PAGES_N*fbce_pkg::PAGE_MAX-1];

  // link domain, cleared by deselect
  logic [5:0]  hdr_r;
  logic [2:0]  bpos_r;
  logic [22:0] sh_r;
  logic [8:0]  ptr_r;
  logic        so_r;
  logic        so_oe_n_r;
  // link domain, kept across deselect; op_r, page_r, ok_r and tgl_r feed the engine
  logic [7:0]  op_r;
  logic [10:0] page_r;
  logic        ok_r;
  logic        tgl_r;
  logic        lp1_r;
  logic        lp2_r;

  // core domain
  fbce_st_t    state_r;
  logic [8:0]  idx_r;
  logic [10:0] cpage_r;
  logic        csel_r;
  logic        clast264_r;
  logic        epe_r;
  logic        seen_r;
  logic        cs1_r;
  logic        cs2_r;
  logic        cs3_r;
  logic        t1_r;
  logic        t2_r;
  logic        cp1_r;
  logic        cp2_r;
  logic [7:0]  arr_data_r;

  // opcode decode
  logic        rd_op;
  logic        fast_op;
  logic        wr_op;
  logic        prog_op;
  logic        erase_op;
  logic        sel_b;
  logic [23:0] addr_w;
  logic [5:0]  dstart;
  logic        dphase;
  logic [8:0]  last_ptr;
  logic [BW-1:0] lbuf_idx;
  logic [7:0]  rbyte;

  assign rd_op   = (op_r == fbce_pkg::OP_BRD1_FAST) || (op_r == fbce_pkg::OP_BRD2_FAST) ||
                   (op_r == fbce_pkg::OP_BRD1_SLOW) || (op_r == fbce_pkg::OP_BRD2_SLOW);
  assign fast_op = (op_r == fbce_pkg::OP_BRD1_FAST) || (op_r == fbce_pkg::OP_BRD2_FAST);
  assign wr_op   = (op_r == fbce_pkg::OP_BWR1) || (op_r == fbce_pkg::OP_BWR2) ||
                   (op_r == fbce_pkg::OP_PTB1) || (op_r == fbce_pkg::OP_PTB2);
  assign erase_op = (op_r == fbce_pkg::OP_PGE1) || (op_r == fbce_pkg::OP_PGE2) ||
                    (op_r == fbce_pkg::OP_PTB1) || (op_r == fbce_pkg::OP_PTB2);
  assign prog_op = erase_op || (op_r == fbce_pkg::OP_PGN1) ||
                   (op_r == fbce_pkg::OP_PGN2);
  assign sel_b   = (op_r == fbce_pkg::OP_BRD2_FAST) || (op_r == fbce_pkg::OP_BRD2_SLOW) ||
                   (op_r == fbce_pkg::OP_BWR2) || (op_r == fbce_pkg::OP_PGE2) ||
                   (op_r == fbce_pkg::OP_PGN2) || (op_r == fbce_pkg::OP_PTB2);

  assign addr_w   = {sh_r, link.si};
  assign dstart   = fast_op ? fbce_pkg::HDR_DATA_FAST : fbce_pkg::HDR_DATA;
  assign dphase   = hdr_r >= dstart;
  assign last_ptr = lp2_r ? fbce_pkg::LAST_264 : fbce_pkg::LAST_256;
  assign lbuf_idx = BW'(ptr_r) + (sel_b ? BW'(fbce_pkg::PAGE_MAX) : BW'(0));
  assign rbyte    = buf_mem[lbuf_idx];

  // strap seen at the link; only read while a frame runs
  always_ff @(posedge link.sck or negedge nrst_i) begin
    if (!nrst_i) begin
      lp1_r <= 1'b0;
      lp2_r <= 1'b0;
    end else begin
      lp1_r <= page264_i;
      lp2_r <= lp1_r;
    end
  end

  // frame shifter; deselect clears it since the clock may stop right after
  always_ff @(posedge link.sck or posedge link.cs_n or negedge nrst_i) begin
    if (!nrst_i) begin
      hdr_r  <= 6'h00;
      bpos_r <= 3'h0;
      sh_r   <= 23'h00_0000;
      ptr_r  <= 9'h000;
    end else if (link.cs_n) begin
      hdr_r  <= 6'h00;
      bpos_r <= 3'h0;
      sh_r   <= 23'h00_0000;
      ptr_r  <= 9'h000;
    end else begin
      hdr_r  <= (hdr_r == fbce_pkg::HDR_SAT) ? hdr_r : hdr_r + 6'h01;
      bpos_r <= bpos_r + 3'h1;
      sh_r   <= addr_w[22:0];
      if (hdr_r == fbce_pkg::HDR_ADDR_LAST) begin
        ptr_r <= lp2_r ? addr_w[8:0] : {1'b0, addr_w[7:0]};
      end else if (dphase && (bpos_r == fbce_pkg::BIT_LAST) && (rd_op || wr_op)) begin
        ptr_r <= (ptr_r == last_ptr) ? 9'h000 : ptr_r + 9'h001;
      end
    end
  end

  // command state that must outlive the frame for the engine
  always_ff @(posedge link.sck or negedge nrst_i) begin
    if (!nrst_i) begin
      op_r   <= 8'h00;
      page_r <= 11'h000;
      ok_r   <= 1'b0;
      tgl_r  <= 1'b0;
    end else if (!link.cs_n) begin
      if (hdr_r == 6'h00) begin
        tgl_r <= ~tgl_r;
      end
      if (hdr_r == fbce_pkg::HDR_OP_LAST) begin
        op_r <= addr_w[7:0];
      end
      if (hdr_r == fbce_pkg::HDR_ADDR_LAST) begin
        page_r <= lp2_r ? addr_w[fbce_pkg::PAGE_LSB_264 +: fbce_pkg::PAGE_W]
                        : addr_w[fbce_pkg::PAGE_LSB_256 +: fbce_pkg::PAGE_W];
      end
      // armed only after whole bytes past the address
      ok_r <= prog_op && (hdr_r >= fbce_pkg::HDR_ADDR_LAST) &&
              (bpos_r == fbce_pkg::BIT_LAST);
    end
  end

  // buffer loading
  always_ff @(posedge link.sck) begin
    if (!link.cs_n && wr_op && dphase && (bpos_r == fbce_pkg::BIT_LAST)) begin
      buf_mem[lbuf_idx] <= addr_w[7:0];
    end
  end

  // read data leaves on the falling edge
  always_ff @(negedge link.sck or posedge link.cs_n or negedge nrst_i) begin
    if (!nrst_i) begin
      so_r      <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else if (link.cs_n) begin
      so_r      <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else if (rd_op && dphase) begin
      so_r      <= rbyte[~bpos_r];
      so_oe_n_r <= 1'b0;
    end
  end

  assign link.so      = so_r;
  assign link.so_oe_n = so_oe_n_r;

  // core side synchronisers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs1_r <= 1'b1;
      cs2_r <= 1'b1;
      cs3_r <= 1'b1;
      t1_r  <= 1'b0;
      t2_r  <= 1'b0;
      cp1_r <= 1'b0;
      cp2_r <= 1'b0;
    end else begin
      cs1_r <= link.cs_n;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      t1_r  <= tgl_r;
      t2_r  <= t1_r;
      cp1_r <= page264_i;
      cp2_r <= cp1_r;
    end
  end

  // engine; op_r, page_r and ok_r are still once the frame has ended
  logic          cs_rise;
  logic          new_frame;
  logic          idx_last;
  logic [AW-1:0] arr_idx;
  logic [BW-1:0] cbuf_idx;
  logic [7:0]    pvalue;

  assign cs_rise   = cs2_r && !cs3_r;
  assign new_frame = cs_rise && (t2_r != seen_r);
  assign idx_last  = idx_r == (clast264_r ? fbce_pkg::LAST_264 : fbce_pkg::LAST_256);
  assign arr_idx   = AW'(cpage_r) * AW'(fbce_pkg::PAGE_MAX) + AW'(idx_r);
  assign cbuf_idx  = BW'(idx_r) + (csel_r ? BW'(fbce_pkg::PAGE_MAX) : BW'(0));
  // programming can only clear bits
  assign pvalue    = arr_mem[arr_idx] & buf_mem[cbuf_idx];

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r    <= ST_IDLE;
      idx_r      <= 9'h000;
      cpage_r    <= 11'h000;
      csel_r     <= 1'b0;
      clast264_r <= 1'b0;
      epe_r      <= 1'b0;
      seen_r     <= 1'b0;
    end else begin
      if (new_frame) begin
        seen_r <= t2_r;
      end
      case (state_r)
        ST_IDLE: begin
          if (new_frame && ok_r) begin
            cpage_r    <= page_r;
            csel_r     <= sel_b;
            clast264_r <= cp2_r;
            idx_r      <= 9'h000;
            epe_r      <= 1'b0;
            state_r    <= erase_op ? ST_ERASE : ST_PROG;
          end
        end
        ST_ERASE: begin
          idx_r <= idx_last ? 9'h000 : idx_r + 9'h001;
          if (idx_last) begin
            state_r <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (pvalue != buf_mem[cbuf_idx]) begin
            epe_r <= 1'b1;
          end
          idx_r <= idx_last ? 9'h000 : idx_r + 9'h001;
          if (idx_last) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // main array writes and observation port
  always_ff @(posedge core_clk_i) begin
    if (state_r == ST_ERASE) begin
      arr_mem[arr_idx] <= fbce_pkg::ERASED;
    end else if (state_r == ST_PROG) begin
      arr_mem[arr_idx] <= pvalue;
    end
    arr_data_r <= arr_mem[AW'(arr_page_i) * AW'(fbce_pkg::PAGE_MAX) + AW'(arr_byte_i)];
  end

  assign busy_o                     = state_r != ST_IDLE;
  assign erase_program_error_flag_o = epe_r;
  assign arr_data_o                 = arr_data_r;

endmodule : fbce_dev
`default_nettype wire

// >>> hdl/fbce_host.sv
// serial host controller end of the flash buffer command engine
`default_nettype none
module fbce_host #(
  parameter int HALF_DIV = fbce_pkg::HALF_DIV_DEF
) (
  // core clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // command
  input  wire logic        start_i,
  input  wire logic [7:0]  op_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [9:0]  len_i,
  output logic             busy_o,
  // write data
  input  wire logic [7:0]  wr_data_i,
  output logic             wr_take_o,
  // read data
  output logic [7:0]       rd_data_o,
  output logic             rd_valid_o,
  // serial link
  fbce_link_if.host        link
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_RUN  = 4'b0010,
    H_END  = 4'b0100,
    H_GAP  = 4'b1000
  } fbce_hst_t;

  fbce_hst_t   state_r;
  logic [7:0]  div_r;
  logic        sck_r;
  logic        cs_n_r;
  logic        si_r;
  logic [7:0]  tx_r;
  logic [7:0]  rx_r;
  logic [13:0] bit_r;
  logic [13:0] total_r;
  logic [7:0]  op_r;
  logic [23:0] addr_r;
  logic [7:0]  rd_data_r;
  logic        rd_valid_r;
  logic        wr_take_r;
  logic        so1_r;
  logic        so2_r;

  logic        tick;
  logic        fast_op;
  logic        rd_op;
  logic        wr_op;
  logic [2:0]  hdr_n;
  logic [10:0] bidx;
  logic [7:0]  nbyte;

  assign tick    = div_r == 8'h00;
  assign fast_op = (op_r == fbce_pkg::OP_BRD1_FAST) || (op_r == fbce_pkg::OP_BRD2_FAST);
  assign rd_op   = fast_op || (op_r == fbce_pkg::OP_BRD1_SLOW) ||
                   (op_r == fbce_pkg::OP_BRD2_SLOW);
  assign wr_op   = (op_r == fbce_pkg::OP_BWR1) || (op_r == fbce_pkg::OP_BWR2) ||
                   (op_r == fbce_pkg::OP_PTB1) || (op_r == fbce_pkg::OP_PTB2);
  assign hdr_n   = fast_op ? fbce_pkg::HDR_BYTES_FAST : fbce_pkg::HDR_BYTES;
  assign bidx    = bit_r[13:3];

  // byte that starts at the next bit
  always_comb begin
    case (bidx)
      11'h001: nbyte = addr_r[23:16];
      11'h002: nbyte = addr_r[15:8];
      11'h003: nbyte = addr_r[7:0];
      default: nbyte = (wr_op && (bidx >= 11'(hdr_n))) ? wr_data_i : 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      so1_r <= 1'b0;
      so2_r <= 1'b0;
    end else begin
      so1_r <= link.so_line;
      so2_r <= so1_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r    <= H_IDLE;
      div_r      <= 8'h00;
      sck_r      <= 1'b0;
      cs_n_r     <= 1'b1;
      si_r       <= 1'b0;
      tx_r       <= 8'h00;
      rx_r       <= 8'h00;
      bit_r      <= 14'h0000;
      total_r    <= 14'h0000;
      op_r       <= 8'h00;
      addr_r     <= 24'h00_0000;
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
      wr_take_r  <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      wr_take_r  <= 1'b0;
      div_r      <= (tick || state_r == H_IDLE) ? 8'(HALF_DIV - 1) : div_r - 8'h01;
      case (state_r)
        H_IDLE: begin
          if (start_i) begin
            op_r    <= op_i;
            addr_r  <= addr_i;
            cs_n_r  <= 1'b0;
            si_r    <= op_i[7];
            tx_r    <= op_i;
            bit_r   <= 14'h0000;
            total_r <= {11'(len_i) + (((op_i == fbce_pkg::OP_BRD1_FAST) ||
                        (op_i == fbce_pkg::OP_BRD2_FAST)) ? 11'(fbce_pkg::HDR_BYTES_FAST)
                        : 11'(fbce_pkg::HDR_BYTES)), 3'h0};
            state_r <= H_RUN;
          end
        end
        H_RUN: begin
          if (tick && !sck_r) begin
            sck_r <= 1'b1;
            bit_r <= bit_r + 14'h0001;
          end else if (tick) begin
            sck_r <= 1'b0;
            // sampled at the end of the high phase: the synchroniser lags two core cycles
            rx_r  <= {rx_r[6:0], so2_r};
            if (rd_op && (bidx > 11'(hdr_n)) && (bit_r[2:0] == 3'h0)) begin
              rd_data_r  <= {rx_r[6:0], so2_r};
              rd_valid_r <= 1'b1;
            end
            if (bit_r == total_r) begin
              state_r <= H_END;
            end else if (bit_r[2:0] == 3'h0) begin
              si_r      <= nbyte[7];
              tx_r      <= nbyte;
              wr_take_r <= wr_op && (bidx >= 11'(hdr_n));
            end else begin
              si_r <= tx_r[~bit_r[2:0]];
            end
          end
        end
        H_END: begin
          if (tick) begin
            cs_n_r  <= 1'b1;
            state_r <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick) begin
            state_r <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign link.sck   = sck_r;
  assign link.cs_n  = cs_n_r;
  assign link.si    = si_r;
  assign busy_o     = state_r != H_IDLE;
  assign wr_take_o  = wr_take_r;
  assign rd_data_o  = rd_data_r;
  assign rd_valid_o = rd_valid_r;

endmodule : fbce_host
`default_nettype wire

// >>> hdl/fbce_link_if.sv
// serial link between host controller and flash command engine
`default_nettype none
interface fbce_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe_n;
  logic so_line;
  // no tri-state on chip: a released output reads as the pull-up level
  assign so_line = so_oe_n ? 1'b1 : so;
  modport dev  (input sck, input cs_n, input si, output so, output so_oe_n);
  modport host (output sck, output cs_n, output si, input so_line);
endinterface : fbce_link_if
`default_nettype wire

// >>> hdl/fbce_pkg.sv
// shared constants for the flash buffer command engine
`default_nettype none
package fbce_pkg;
  // opcodes
  localparam logic [7:0] OP_BRD1_FAST = 8'hD4;
  localparam logic [7:0] OP_BRD2_FAST = 8'hD6;
  localparam logic [7:0] OP_BRD1_SLOW = 8'hD1;
  localparam logic [7:0] OP_BRD2_SLOW = 8'hD3;
  localparam logic [7:0] OP_BWR1      = 8'h84;
  localparam logic [7:0] OP_BWR2      = 8'h87;
  localparam logic [7:0] OP_PGE1      = 8'h83;
  localparam logic [7:0] OP_PGE2      = 8'h86;
  localparam logic [7:0] OP_PGN1      = 8'h88;
  localparam logic [7:0] OP_PGN2      = 8'h89;
  localparam logic [7:0] OP_PTB1      = 8'h82;
  localparam logic [7:0] OP_PTB2      = 8'h85;
  // frame layout, counted in serial clock rising edges, header lengths in bytes
  localparam logic [5:0] HDR_OP_LAST   = 6'h07;
  localparam logic [5:0] HDR_ADDR_LAST = 6'h1F;
  localparam logic [5:0] HDR_DATA      = 6'h20;
  localparam logic [5:0] HDR_DATA_FAST = 6'h28;
  localparam logic [5:0] HDR_SAT       = 6'h3F;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [2:0] HDR_BYTES      = 3'h4;
  localparam logic [2:0] HDR_BYTES_FAST = 3'h5;
  // address fields
  localparam int PAGE_W       = 11;
  localparam int PAGE_LSB_264 = 9;
  localparam int PAGE_LSB_256 = 8;
  // buffer and page geometry
  localparam logic [8:0] LAST_264 = 9'h107;
  localparam logic [8:0] LAST_256 = 9'h0FF;
  localparam int         PAGE_MAX = 264;
  localparam int         PAGES_DEF = 2048;
  localparam logic [7:0] ERASED   = 8'hFF;
  // host serial clock divider, half period in core clocks
  localparam int HALF_DIV_DEF = 8;
endpackage : fbce_pkg
`default_nettype wire

// >>> sim/fbce_link_chk.sv
// concurrent checks on the serial link between host and device ends
`default_nettype none
module fbce_link_chk #(
  parameter int HALF_DIV = fbce_pkg::HALF_DIV_DEF
) (
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // link signals
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sck_q_r;
  logic [5:0] rise_cnt_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] op_r;
  logic [7:0] high_cnt_r;
  logic       rise;
  logic       fast;
  logic       rd_op;
  assign rise  = sck && !sck_q_r;
  assign fast  = (op_r == fbce_pkg::OP_BRD1_FAST) || (op_r == fbce_pkg::OP_BRD2_FAST);
  assign rd_op = fast || (op_r == fbce_pkg::OP_BRD1_SLOW) || (op_r == fbce_pkg::OP_BRD2_SLOW);
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_q_r    <= 1'b0;
      high_cnt_r <= 8'h00;
    end else begin
      sck_q_r    <= sck;
      high_cnt_r <= sck ? high_cnt_r + 8'h01 : 8'h00;
    end
  end
  // count saturates: only the header boundaries matter here
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rise_cnt_r <= 6'h00;
      bit_cnt_r  <= 3'h0;
    end else if (cs_n) begin
      rise_cnt_r <= 6'h00;
      bit_cnt_r  <= 3'h0;
    end else if (rise) begin
      rise_cnt_r <= (rise_cnt_r == 6'h3F) ? rise_cnt_r : rise_cnt_r + 6'h01;
      bit_cnt_r  <= bit_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_r <= 8'h00;
    end else if (rise && rise_cnt_r < 6'h08) begin
      op_r <= {op_r[6:0], si};
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // setup window assumes a divider of two or more
  sequence s_open;
    $fell(cs_n);
  endsequence
  sequence s_setup;
    !sck [*2];
  endsequence
  property p_open;      s_open |-> s_setup;                        endproperty
  property p_idle_clk;  cs_n |-> !sck;                             endproperty
  property p_half;      $fell(sck) |-> high_cnt_r == HALF_DIV;     endproperty
  property p_so_steady; sck |-> $stable(so);                       endproperty
  property p_release;   cs_n |-> so_oe_n;                          endproperty
  property p_out_read;  !so_oe_n |-> rd_op && rise_cnt_r >= 6'h20; endproperty
  property p_fast_wait; (!so_oe_n && fast) |-> rise_cnt_r >= 6'h28; endproperty
  property p_bytes;     $rose(cs_n) |-> bit_cnt_r == 3'h0;         endproperty
  a_open:      assert property (p_open) else $error("clock rose too soon after select");
  a_idle_clk:  assert property (p_idle_clk) else $error("clock high while deselected");
  a_half:      assert property (p_half) else $error("clock high phase wrong length");
  a_so_steady: assert property (p_so_steady) else $error("output changed with clock high");
  a_release:   assert property (p_release) else $error("output driven while deselected");
  a_out_read:  assert property (p_out_read) else $error("output driven outside read data");
  a_fast_wait: assert property (p_fast_wait) else $error("fast read skipped dummy byte");
  a_bytes:     assert property (p_bytes) else $error("frame ended off a byte boundary");
endmodule : fbce_link_chk
`default_nettype wire

// >>> sim/flash_buffer_command_engine_tb_top.sv
// self-checking bench: host and device ends joined over the serial link
`default_nettype none
module flash_buffer_command_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HD = 2;
  logic        core_clk_i, nrst_i, page264, start, host_busy, wr_take, rd_valid;
  logic        dev_busy, erase_program_error_flag, busy_b;
  logic [7:0]  op, wr_data, rd_data, arr_data, wop;
  logic [23:0] addr;
  logic [9:0]  len;
  logic [10:0] arr_page;
  logic [8:0]  arr_byte;
  logic [7:0]  wdat [265];
  logic [7:0]  bufm [2][264];
  logic [7:0]  pgm [4][264];
  logic [7:0]  rops [4];
  logic [7:0]  rdq [$];
  int          wi, wbits, seed, psz, mismatches, total_checks;
  fbce_link_if lk ();
  fbce_link_if lk2 ();
  fbce_host #(.HALF_DIV(HD)) i_fbce_host (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .start_i(start), .op_i(op), .addr_i(addr), .len_i(len), .busy_o(host_busy),
    .wr_data_i(wr_data), .wr_take_o(wr_take), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .link(lk));
  fbce_dev #(.PAGES_N(4)) i_fbce_dev (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .page264_i(page264), .busy_o(dev_busy), .erase_program_error_flag_o(erase_program_error_flag),
    .arr_page_i(arr_page), .arr_byte_i(arr_byte), .arr_data_o(arr_data), .link(lk));
  fbce_dev #(.PAGES_N(4)) i_fbce_dev_b (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .page264_i(page264), .busy_o(busy_b), .erase_program_error_flag_o(),
    .arr_page_i(arr_page), .arr_byte_i(arr_byte), .arr_data_o(), .link(lk2));
  fbce_link_chk #(.HALF_DIV(HD)) i_fbce_link_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .sck(lk.sck), .cs_n(lk.cs_n), .si(lk.si), .so(lk.so), .so_oe_n(lk.so_oe_n));
  assign wr_data = wdat[wi];
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (wr_take === 1'b1) wi <= wi + 1;
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
  end
  always @(negedge lk.cs_n) wbits <= 0;
  always @(posedge lk.sck) begin
    if (lk.cs_n === 1'b0 && wbits < 8) begin
      wop   <= {wop[6:0], lk.si};
      wbits <= wbits + 1;
    end
  end
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask : tick
  function automatic logic [23:0] buf_addr(input int idx);
    return page264 ? {15'h0, 9'(idx)} : {16'h0, 8'(idx)};
  endfunction : buf_addr
  function automatic logic [23:0] pg_addr(input int pg, input int idx);
    return page264 ? {4'h0, 11'(pg), 9'(idx)} : {5'h0, 11'(pg), 8'(idx)};
  endfunction : pg_addr
  task automatic cmd(input logic [7:0] o, input logic [23:0] a, input int n);
    int k;
    tick();
    op = o;
    addr = a;
    len = 10'(n);
    wi = 0;
    rdq.delete();
    start = 1'b1;
    tick();
    start = 1'b0;
    k = 0;
    while (host_busy !== 1'b0 && k < 20000) begin
      tick();
      k++;
    end
    if (k >= 20000) begin
      mismatches++;
      wrap_up();
    end
    check("wire_opcode", 32'(wop), 32'(o));
    repeat (4) tick();
  endtask : cmd
  // random bytes into the load queue and the buffer model, wrapping at the page size
  task automatic fill(input int b, input int idx, input int n);
    for (int k = 0; k < n; k++) begin
      wdat[k] = 8'($random(seed));
      bufm[b][(idx + k) % psz] = wdat[k];
    end
  endtask : fill
  task automatic rd_chk(input logic [7:0] o, input int b, input int idx, input int n);
    cmd(o, buf_addr(idx), n);
    check("rd_count", rdq.size(), n);
    for (int k = 0; k < n; k++) begin
      check("rd_data", 32'(rdq[k]), 32'(bufm[b][(idx + k) % psz]));
    end
    check("so_released", 32'(lk.so_oe_n), 32'h1);
  endtask : rd_chk
  task automatic prog(input logic [7:0] o, input int b, input int pg, input int idx,
                      input int n, input bit erase, input bit poke);
    logic err;
    int   k;
    err = 1'b0;
    fill(b, idx, n);
    for (k = 0; k < psz; k++) begin
      if (erase) pgm[pg][k] = 8'hFF;
      pgm[pg][k] = pgm[pg][k] & bufm[b][k];
      if (pgm[pg][k] !== bufm[b][k]) err = 1'b1;
    end
    cmd(o, pg_addr(pg, idx), n);
    if (poke) cmd(fbce_pkg::OP_PGE2, pg_addr(pg, 0), 0);
    repeat (6) tick();
    check("dev_busy", 32'(dev_busy), 32'h1);
    k = 0;
    while (dev_busy !== 1'b0 && k < 2000) begin
      tick();
      k++;
    end
    if (k >= 2000) begin
      mismatches++;
      wrap_up();
    end
    check("epe_flag", 32'(erase_program_error_flag), 32'(err));
    for (k = 0; k < psz; k++) begin
      arr_page = 11'(pg);
      arr_byte = 9'(k);
      tick();
      tick();
      check("array", 32'(arr_data), 32'(pgm[pg][k]));
    end
  endtask : prog
  // bench stands in for the host here so a frame can end mid-byte
  task automatic frame2(input int extra);
    logic [31:0] w;
    w = {fbce_pkg::OP_PGE1, pg_addr(0, 0)};
    #37 lk2.cs_n = 1'b0;
    for (int k = 0; k < 32 + extra; k++) begin
      lk2.si = w[31 - (k % 32)];
      #80 lk2.sck = 1'b1;
      #80 lk2.sck = 1'b0;
    end
    #80 lk2.cs_n = 1'b1;
    lk2.si = ~lk2.si;
    repeat (20) tick();
    check("abort_busy", 32'(busy_b), 32'(extra == 0));
  endtask : frame2
  initial begin
    seed = 81;
    mismatches = 0;
    total_checks = 0;
    wi = 0;
    wbits = 0;
    wop = 8'h00;
    start = 1'b0;
    op = 8'h00;
    addr = 24'h00_0000;
    len = 10'h000;
    page264 = 1'b1;
    psz = 264;
    arr_page = 11'h000;
    arr_byte = 9'h000;
    lk2.sck = 1'b0;
    lk2.cs_n = 1'b1;
    lk2.si = 1'b0;
    rops = '{fbce_pkg::OP_BRD1_FAST, fbce_pkg::OP_BRD1_SLOW,
             fbce_pkg::OP_BRD2_FAST, fbce_pkg::OP_BRD2_SLOW};
    nrst_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1 nrst_i = 1'b1;
    for (int b = 0; b < 2; b++) begin
      fill(b, 0, psz);
      cmd(b ? fbce_pkg::OP_BWR2 : fbce_pkg::OP_BWR1, buf_addr(0), psz);
    end
    fill(0, 261, 6);
    cmd(fbce_pkg::OP_BWR1, buf_addr(261), 6);
    for (int k = 0; k < 4; k++) rd_chk(rops[k], k / 2, 259 + k, 8);
    prog(fbce_pkg::OP_PGE1, 0, 1, 0, 0, 1'b1, 1'b1);
    prog(fbce_pkg::OP_PTB2, 1, 2, 256, 10, 1'b1, 1'b0);
    prog(fbce_pkg::OP_PTB1, 0, 0, 200, 5, 1'b1, 1'b0);
    prog(fbce_pkg::OP_PGN1, 0, 2, 0, 0, 1'b0, 1'b0);
    prog(fbce_pkg::OP_PGE2, 1, 3, 0, 0, 1'b1, 1'b0);
    prog(fbce_pkg::OP_PGN2, 1, 3, 0, 0, 1'b0, 1'b0);
    page264 = 1'b0;
    psz = 256;
    fill(0, 252, 6);
    cmd(fbce_pkg::OP_BWR1, buf_addr(252), 6);
    rd_chk(fbce_pkg::OP_BRD1_FAST, 0, 252, 6);
    prog(fbce_pkg::OP_PGE1, 0, 3, 0, 0, 1'b1, 1'b0);
    frame2(3);
    frame2(0);
    wrap_up();
  end
endmodule : flash_buffer_command_engine_tb_top
`default_nettype wire
